// >>> hdl/bserr_pkg.sv
// Package of constants for the bridge system error reporting block
package bserr_pkg;

  // Register indices on the plain register port
  localparam logic [3:0] BSERR_ADDR_CMD = 4'h0;
  localparam logic [3:0] BSERR_ADDR_BCTL = 4'h1;
  localparam logic [3:0] BSERR_ADDR_PSTAT = 4'h2;
  localparam logic [3:0] BSERR_ADDR_SSTAT = 4'h3;
  localparam logic [3:0] BSERR_ADDR_REASON = 4'h4;
  localparam logic [3:0] BSERR_ADDR_DISABLE = 4'h5;
  localparam logic [3:0] BSERR_ADDR_LIMIT = 4'h6;
  localparam logic [3:0] BSERR_ADDR_LOCK = 4'h7;

  // Command register fields
  localparam int BSERR_CMD_PERR_EN = 0;
  localparam int BSERR_CMD_SERR_EN = 1;
  // Bridge control fields
  localparam int BSERR_BCTL_PERR_EN = 0;
  localparam int BSERR_BCTL_SERR_FWD = 1;
  localparam int BSERR_BCTL_MTO_SERR = 2;
  // Status fields
  localparam int BSERR_PSTAT_SIG_SERR = 0;
  localparam int BSERR_SSTAT_RCV_SERR = 0;

  // Event numbering, shared by reason and disable registers
  localparam int BSERR_NEV = 8;
  localparam int BSERR_EV_PARITY = 0;
  localparam int BSERR_EV_TABORT = 1;
  localparam int BSERR_EV_MABORT = 2;
  localparam int BSERR_EV_PW_RETRY = 3;
  localparam int BSERR_EV_DW_RETRY = 4;
  localparam int BSERR_EV_DR_RETRY = 5;
  localparam int BSERR_EV_MTO = 6;
  localparam int BSERR_EV_SFWD = 7;
  // Master timeout has no disable bit
  localparam logic [7:0] BSERR_DIS_MASK = 8'h3f;

  // Retry counter sources
  localparam int BSERR_NCNT = 3;
  localparam int BSERR_CNT_W = 25;

  // Reset values
  localparam logic [1:0] BSERR_CMD_RST = 2'h0;
  localparam logic [2:0] BSERR_BCTL_RST = 3'h0;
  localparam logic [7:0] BSERR_DIS_RST = 8'h00;
  localparam logic [24:0] BSERR_LIMIT_RST = 25'h1000000;

  // Event sequencer states
  typedef enum logic [2:0] {
    BSERR_IDLE = 3'b001,
    BSERR_DRIVE = 3'b010,
    BSERR_HOLD = 3'b100
  } bserr_state_e;

endpackage

// >>> hdl/bserr_cnt_if.sv
// Interface between the top and the retry counter bank
`timescale 1ns/1ns
interface bserr_cnt_if;
  logic [2:0] retry;
  logic [2:0] done;
  logic [24:0] limit;
  logic [2:0] expired;
  modport top (output retry, output done, output limit, input expired);
  modport bank (input retry, input done, input limit, output expired);
endinterface

// >>> hdl/bserr_retry_bank.sv
// Retry counters, one per transaction kind
`timescale 1ns/1ns
module bserr_retry_bank
  import bserr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Counter control
  bserr_cnt_if.bank cnt
);

  genvar gi;
  generate
    for (gi = 0; gi < BSERR_NCNT; gi++)
    begin : g_cnt
      logic [24:0] count_r;
      logic [24:0] count_nxt;
      logic hit;
      logic exp_r;
      assign hit = cnt.retry[gi] && (count_r + 25'h1 >= cnt.limit);
      assign count_nxt = (cnt.done[gi] || hit) ? 25'h0 :
                         cnt.retry[gi] ? count_r + 25'h1 : count_r;
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          count_r <= 25'h0;
          exp_r <= 1'b0;
        end
        else
        begin
          count_r <= count_nxt;
          exp_r <= hit;
        end
      end
      assign cnt.expired[gi] = exp_r;
    end
  endgenerate

endmodule // bserr_retry_bank

// >>> hdl/bserr_top.sv
// System error and parity error reporting of a two-sided bridge
//
// Operation
// - Parity line seen on downstream or upstream posted write can raise system error.
// - No system error when bridge itself caught the error as write target.
// - Posted write parity system error needs both parity response enables set.
// - System error output is never driven without the command system error enable.
// - Every system error assertion sets the signaled system error status flag.
// - Secondary system error input with forwarding enabled raises primary system error.
// - Secondary system error input sets received system error secondary status flag.
// - Target abort on posted write delivery is a conditional system error cause.
// - Master abort on posted write delivery is a conditional system error cause.
// - Posted write retries are counted; data dropped at limit, cause flagged.
// - Delayed write dropped after retry limit is a conditional cause.
// - Delayed read failing after retry limit is a conditional cause.
// - Master timeout on a delayed transaction is a conditional cause.
// - Reason register records which event caused each system error assertion.
// - Per-event disable register lets software suppress individual causes.
// - Master timeout gated by its bridge control enable and the command system error enable, never disabled.
// - Primary and secondary locks run independently unless a lock crosses.
// - Secondary parity line driven as secondary write target or read initiator.
// - Secondary parity line also driven on primary parity during upstream delayed write.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
module bserr_top
  import bserr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Parity error lines, active low
  input wire logic primary_parity_error_line_n,
  input wire logic secondary_parity_error_line_in_n,
  output logic secondary_parity_error_line_out_n,
  output logic secondary_parity_error_line_oe_n,
  // System error lines, active low
  input wire logic secondary_system_error_in_n,
  output logic primary_system_error_out_n,
  output logic primary_system_error_oe_n,
  // Posted write delivery status
  input wire logic pw_active,
  input wire logic pw_downstream,
  input wire logic pw_self_target_perr,
  input wire logic pw_target_abort,
  input wire logic pw_master_abort,
  input wire logic pw_retry,
  input wire logic pw_done,
  output logic pw_discard,
  // Delayed transaction status
  input wire logic dw_retry,
  input wire logic dw_done,
  output logic dw_discard,
  input wire logic dr_retry,
  input wire logic dr_done,
  output logic dr_discard,
  input wire logic dt_master_timeout,
  input wire logic udw_completion,
  // Secondary side parity detection
  input wire logic sec_perr_detect,
  input wire logic sec_write_target,
  input wire logic sec_read_initiator,
  // Lock status
  input wire logic pri_lock_req,
  input wire logic sec_lock_req,
  input wire logic lock_crossing,
  output logic pri_lock_held,
  output logic sec_lock_held
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [1:0] cmd_r;
  logic [2:0] bctl_r;
  logic pstat_r;
  logic sstat_r;
  logic [7:0] reason_r;
  logic [7:0] dis_r;
  logic [24:0] limit_r;
  logic [31:0] rdata_r;
  bserr_state_e state_r;
  bserr_state_e state_nxt;
  logic serr_oe_n_r;
  logic sperr_oe_n_r;
  logic [2:0] disc_r;
  logic plock_r;
  logic slock_r;

  bserr_cnt_if cnt_if ();

  bserr_retry_bank u_bank (
    .core_clk(core_clk),
    .rst(rst),
    .cnt(cnt_if.bank)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Retry counting
  assign cnt_if.retry = {dr_retry, dw_retry, pw_retry};
  assign cnt_if.done = {dr_done, dw_done, pw_done};
  assign cnt_if.limit = limit_r;

  ////////////////////////////////////////////////////////////////////////////
  // Event decode
  wire perr_en_both = cmd_r[BSERR_CMD_PERR_EN] &&
                      bctl_r[BSERR_BCTL_PERR_EN];
  wire pw_line_seen = pw_downstream ? !secondary_parity_error_line_in_n :
                      !primary_parity_error_line_n;
  wire ev_parity = pw_active && pw_line_seen &&
                   !pw_self_target_perr && perr_en_both;
  wire ev_sfwd = !secondary_system_error_in_n &&
                 bctl_r[BSERR_BCTL_SERR_FWD];
  wire ev_mto = dt_master_timeout &&
                bctl_r[BSERR_BCTL_MTO_SERR];
  wire [7:0] ev_raw;
  assign ev_raw[BSERR_EV_PARITY] = ev_parity;
  assign ev_raw[BSERR_EV_TABORT] = pw_active && pw_target_abort;
  assign ev_raw[BSERR_EV_MABORT] = pw_active && pw_master_abort;
  assign ev_raw[BSERR_EV_PW_RETRY] = cnt_if.expired[0];
  assign ev_raw[BSERR_EV_DW_RETRY] = cnt_if.expired[1];
  assign ev_raw[BSERR_EV_DR_RETRY] = cnt_if.expired[2];
  assign ev_raw[BSERR_EV_MTO] = ev_mto;
  assign ev_raw[BSERR_EV_SFWD] = ev_sfwd;
  // Disable applies only to maskable causes
  wire [7:0] ev_gated = ev_raw & ~(dis_r & BSERR_DIS_MASK);
  wire serr_allowed = cmd_r[BSERR_CMD_SERR_EN];
  wire serr_fire = serr_allowed && (|ev_gated);

  ////////////////////////////////////////////////////////////////////////////
  // Secondary parity decode
  wire sperr_fire = bctl_r[BSERR_BCTL_PERR_EN] &&
                    ((sec_perr_detect &&
                      (sec_write_target || sec_read_initiator)) ||
                     (udw_completion && !primary_parity_error_line_n &&
                      cmd_r[BSERR_CMD_PERR_EN]));

  ////////////////////////////////////////////////////////////////////////////
  // Register access decode
  wire wr_cmd = reg_wr && reg_addr == BSERR_ADDR_CMD;
  wire wr_bctl = reg_wr && reg_addr == BSERR_ADDR_BCTL;
  wire wr_pstat = reg_wr && reg_addr == BSERR_ADDR_PSTAT;
  wire wr_sstat = reg_wr && reg_addr == BSERR_ADDR_SSTAT;
  wire wr_reason = reg_wr && reg_addr == BSERR_ADDR_REASON;
  wire wr_dis = reg_wr && reg_addr == BSERR_ADDR_DISABLE;
  wire wr_limit = reg_wr && reg_addr == BSERR_ADDR_LIMIT;
  wire [31:0] rd_mux =
    reg_addr == BSERR_ADDR_CMD ? {30'h0, cmd_r} :
    reg_addr == BSERR_ADDR_BCTL ? {29'h0, bctl_r} :
    reg_addr == BSERR_ADDR_PSTAT ? {31'h0, pstat_r} :
    reg_addr == BSERR_ADDR_SSTAT ? {31'h0, sstat_r} :
    reg_addr == BSERR_ADDR_REASON ? {24'h0, reason_r} :
    reg_addr == BSERR_ADDR_DISABLE ? {24'h0, dis_r} :
    reg_addr == BSERR_ADDR_LIMIT ? {7'h0, limit_r} :
    reg_addr == BSERR_ADDR_LOCK ? {30'h0, slock_r, plock_r} : 32'h0;

  // Write one to clear, a new event wins over the clear
  wire pstat_nxt = serr_fire ||
                   (pstat_r && !(wr_pstat && reg_wdata[0]));
  wire sstat_nxt = !secondary_system_error_in_n ||
                   (sstat_r && !(wr_sstat && reg_wdata[0]));
  wire [7:0] reason_nxt = (serr_fire ? ev_gated : 8'h0) |
                          (reason_r & ~(wr_reason ? reg_wdata[7:0] : 8'h0));

  ////////////////////////////////////////////////////////////////////////////
  // Output sequencer: drive system error while any cause stands
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      BSERR_IDLE:
        if (serr_fire)
          state_nxt = BSERR_DRIVE;
      BSERR_DRIVE:
        state_nxt = serr_fire ? BSERR_DRIVE : BSERR_HOLD;
      BSERR_HOLD:
        state_nxt = serr_fire ? BSERR_DRIVE : BSERR_IDLE;
      default:
        state_nxt = BSERR_IDLE;
    endcase
  end

  wire serr_nxt = state_nxt == BSERR_DRIVE;

  ////////////////////////////////////////////////////////////////////////////
  // Locks: each bus lock follows its own requester unless one crosses
  wire plock_nxt = pri_lock_req;
  wire slock_nxt = lock_crossing ? pri_lock_req || sec_lock_req :
                   sec_lock_req;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cmd_r <= BSERR_CMD_RST;
      bctl_r <= BSERR_BCTL_RST;
      dis_r <= BSERR_DIS_RST;
      limit_r <= BSERR_LIMIT_RST;
    end
    else
    begin
      if (wr_cmd)
        cmd_r <= reg_wdata[1:0];
      if (wr_bctl)
        bctl_r <= reg_wdata[2:0];
      if (wr_dis)
        dis_r <= reg_wdata[7:0] & BSERR_DIS_MASK;
      if (wr_limit)
        limit_r <= reg_wdata[24:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status, reason and outputs
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pstat_r <= 1'b0;
      sstat_r <= 1'b0;
      reason_r <= 8'h0;
      rdata_r <= 32'h0;
      state_r <= BSERR_IDLE;
      serr_oe_n_r <= 1'b1;
      sperr_oe_n_r <= 1'b1;
      disc_r <= 3'h0;
      plock_r <= 1'b0;
      slock_r <= 1'b0;
    end
    else
    begin
      pstat_r <= pstat_nxt;
      sstat_r <= sstat_nxt;
      reason_r <= reason_nxt;
      rdata_r <= reg_rd ? rd_mux : 32'h0;
      state_r <= state_nxt;
      serr_oe_n_r <= !serr_nxt;
      sperr_oe_n_r <= !sperr_fire;
      disc_r <= cnt_if.expired;
      plock_r <= plock_nxt;
      slock_r <= slock_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port drive; system error is open drain, driven low only
  assign reg_rdata = rdata_r;
  assign primary_system_error_out_n = 1'b0;
  assign primary_system_error_oe_n = serr_oe_n_r;
  assign secondary_parity_error_line_out_n = sperr_oe_n_r;
  assign secondary_parity_error_line_oe_n = sperr_oe_n_r;
  assign pw_discard = disc_r[0];
  assign dw_discard = disc_r[1];
  assign dr_discard = disc_r[2];
  assign pri_lock_held = plock_r;
  assign sec_lock_held = slock_r;

endmodule // bserr_top

// >>> dv/bserr_top_asserts.sv
// Concurrent checks on the error reporting block ports
`timescale 1ns/1ns
module bserr_top_asserts
  import bserr_pkg::*;
(
  // Clock, reset and register port
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // Error lines and events
  input wire logic primary_parity_error_line_n,
  input wire logic secondary_parity_error_line_in_n,
  input wire logic secondary_parity_error_line_oe_n,
  input wire logic secondary_system_error_in_n,
  input wire logic primary_system_error_oe_n,
  input wire logic pw_active,
  input wire logic pw_downstream,
  input wire logic pw_self_target_perr,
  input wire logic pw_retry,
  input wire logic pw_discard,
  input wire logic dt_master_timeout,
  input wire logic udw_completion,
  input wire logic pri_lock_req,
  input wire logic pri_lock_held
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  logic [1:0] cmd_r;
  logic [2:0] bctl_r;
  logic dis0_r;
  //////////////////////////////////////////////////////////////////////////
  // Shadow of the enables as software writes them
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cmd_r <= 2'h0;
      bctl_r <= 3'h0;
      dis0_r <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == BSERR_ADDR_CMD) cmd_r <= reg_wdata[1:0];
      if (reg_addr == BSERR_ADDR_BCTL) bctl_r <= reg_wdata[2:0];
      if (reg_addr == BSERR_ADDR_DISABLE) dis0_r <= reg_wdata[0];
    end
  end
  //////////////////////////////////////////////////////////////////////////
  fwd_raise_a: assert property (
    !secondary_system_error_in_n && cmd_r[1] && bctl_r[1]
    |=> !primary_system_error_oe_n) else $error("forward not raised");
  serr_gate_a: assert property (
    !primary_system_error_oe_n |-> $past(cmd_r[1]))
    else $error("system error without enable");
  parity_raise_a: assert property (
    pw_active && !pw_self_target_perr && (&cmd_r) && bctl_r[0] && !dis0_r
    && (pw_downstream ? !secondary_parity_error_line_in_n
    : !primary_parity_error_line_n) |=> !primary_system_error_oe_n)
    else $error("parity system error missing");
  mto_raise_a: assert property (
    dt_master_timeout && cmd_r[1] && bctl_r[2]
    |=> !primary_system_error_oe_n) else $error("timeout not raised");
  disc_cause_a: assert property (
    pw_discard |-> $past(pw_retry, 2)) else $error("discard without retry");
  disc_pulse_a: assert property (
    pw_discard |=> !pw_discard) else $error("discard longer than a cycle");
  sperr_gate_a: assert property (
    !secondary_parity_error_line_oe_n |-> $past(bctl_r[0]))
    else $error("parity line without enable");
  udw_raise_a: assert property (
    udw_completion && !primary_parity_error_line_n && cmd_r[0] && bctl_r[0]
    |=> !secondary_parity_error_line_oe_n) else $error("udw parity missing");
  lock_rise_a: assert property (
    $rose(pri_lock_held) |-> $past(pri_lock_req))
    else $error("lock held without request");
endmodule // bserr_top_asserts
bind bserr_top bserr_top_asserts chk (.core_clk, .rst, .reg_addr, .reg_wdata,
  .reg_wr, .primary_parity_error_line_n, .secondary_parity_error_line_in_n,
  .secondary_parity_error_line_oe_n, .secondary_system_error_in_n,
  .primary_system_error_oe_n, .pw_active, .pw_downstream,
  .pw_self_target_perr, .pw_retry, .pw_discard, .dt_master_timeout,
  .udw_completion, .pri_lock_req, .pri_lock_held);

// >>> dv/bserr_pci_partner.sv
// Model of the bus agents that raise error events
`timescale 1ns/1ns
module bserr_pci_partner
(
  // Clock, reset and event request
  input wire logic core_clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [3:0] kind,
  // Error lines, pulled up when idle
  output logic primary_parity_error_line_n,
  output logic secondary_parity_error_line_in_n,
  output logic secondary_system_error_in_n,
  // Transaction status
  output logic pw_active,
  output logic pw_downstream,
  output logic pw_self_target_perr,
  output logic pw_target_abort,
  output logic pw_master_abort,
  output logic pw_retry,
  output logic pw_done,
  output logic dw_retry,
  output logic dw_done,
  output logic dr_retry,
  output logic dr_done,
  output logic dt_master_timeout,
  output logic udw_completion,
  output logic sec_perr_detect,
  output logic sec_write_target,
  output logic sec_read_initiator
);
  logic [15:0] ev_r;
  // One event per request, one cycle long
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst) ev_r <= 16'h0000;
    else ev_r <= go ? (16'h0001 << kind) : 16'h0000;
  end
  assign secondary_system_error_in_n = !ev_r[0];
  assign secondary_parity_error_line_in_n = !(ev_r[1] | ev_r[9]);
  assign primary_parity_error_line_n = !(ev_r[2] | ev_r[11]);
  assign pw_active = (|ev_r[5:1]) | ev_r[9];
  assign pw_downstream = ev_r[1] | ev_r[9];
  assign pw_self_target_perr = ev_r[9];
  assign pw_target_abort = ev_r[3];
  assign pw_master_abort = ev_r[4];
  assign pw_retry = ev_r[5];
  assign dw_retry = ev_r[6];
  assign dr_retry = ev_r[7];
  assign dt_master_timeout = ev_r[8];
  assign sec_perr_detect = ev_r[10] | ev_r[12];
  assign sec_write_target = ev_r[10];
  assign udw_completion = ev_r[11];
  assign sec_read_initiator = ev_r[12];
  assign pw_done = ev_r[13];
  assign dw_done = ev_r[13];
  assign dr_done = ev_r[13];
endmodule // bserr_pci_partner

// >>> dv/bserr_top_tb.sv
// Testbench of the bridge system error reporting block
`timescale 1ns/1ns
module bserr_top_tb
  import bserr_pkg::*;
;
  localparam int LIM = 4;
  logic core_clk, rst, reg_wr, reg_rd, go;
  logic [3:0] reg_addr, kind;
  logic [31:0] reg_wdata, reg_rdata, rd_v;
  logic primary_parity_error_line_n, secondary_parity_error_line_in_n;
  logic secondary_parity_error_line_out_n, secondary_parity_error_line_oe_n;
  logic secondary_system_error_in_n;
  logic primary_system_error_out_n, primary_system_error_oe_n;
  logic pw_active, pw_downstream, pw_self_target_perr, pw_target_abort;
  logic pw_master_abort, pw_retry, pw_done, pw_discard, dw_retry, dw_done;
  logic dw_discard, dr_retry, dr_done, dr_discard, dt_master_timeout;
  logic udw_completion, sec_perr_detect, sec_write_target, sec_read_initiator;
  logic pri_lock_req, sec_lock_req, lock_crossing, pri_lock_held;
  logic sec_lock_held;
  logic [1:0] lk_exp;
  int failures, checks, cmd_m, bctl_m, dis_m, seen_s, seen_p, seen_d, e;
  int rb[13] = '{7, 0, 0, 1, 2, 3, 4, 5, 6, -1, -1, -1, -1};
  int rst_tab[7] = '{0, 0, 0, 0, 0, 0, 32'h1000000};
  int c_cmd[4] = '{3, 3, 1, 2};
  int c_bctl[4] = '{7, 7, 7, 2};
  int c_dis[4] = '{0, 63, 0, 0};
  bserr_top dut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .primary_parity_error_line_n, .secondary_parity_error_line_in_n,
    .secondary_parity_error_line_out_n, .secondary_parity_error_line_oe_n,
    .secondary_system_error_in_n, .primary_system_error_out_n,
    .primary_system_error_oe_n, .pw_active, .pw_downstream,
    .pw_self_target_perr, .pw_target_abort, .pw_master_abort, .pw_retry,
    .pw_done, .pw_discard, .dw_retry, .dw_done, .dw_discard, .dr_retry,
    .dr_done, .dr_discard, .dt_master_timeout, .udw_completion,
    .sec_perr_detect, .sec_write_target, .sec_read_initiator, .pri_lock_req,
    .sec_lock_req, .lock_crossing, .pri_lock_held, .sec_lock_held);
  bserr_pci_partner agent (.core_clk, .rst, .go, .kind,
    .primary_parity_error_line_n, .secondary_parity_error_line_in_n,
    .secondary_system_error_in_n, .pw_active, .pw_downstream,
    .pw_self_target_perr, .pw_target_abort, .pw_master_abort, .pw_retry,
    .pw_done, .dw_retry, .dw_done, .dr_retry, .dr_done, .dt_master_timeout,
    .udw_completion, .sec_perr_detect, .sec_write_target, .sec_read_initiator);
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Lock requests wander at random
  always @(posedge core_clk)
  begin
    lk_exp = rst ? 2'h0 : {(lock_crossing ? (pri_lock_req | sec_lock_req) :
      sec_lock_req), pri_lock_req};
    pri_lock_req <= 1'($urandom);
    sec_lock_req <= 1'($urandom);
    lock_crossing <= 1'($urandom);
  end
  // Output watch, away from the sampling edge
  always @(negedge core_clk)
  begin
    if (primary_system_error_oe_n === 1'b0 &&
      primary_system_error_out_n === 1'b0) seen_s = 1;
    if (secondary_parity_error_line_oe_n === 1'b0 &&
      secondary_parity_error_line_out_n === 1'b0) seen_p = 1;
    if (pw_discard === 1'b1) seen_d |= 1;
    if (dw_discard === 1'b1) seen_d |= 2;
    if (dr_discard === 1'b1) seen_d |= 4;
    check("lock", {sec_lock_held, pri_lock_held}, lk_exp);
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask
  task automatic fire(input int k, input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      go <= 1'b1;
      kind <= 4'(k);
      @(posedge core_clk);
      go <= 1'b0;
    end
  endtask
  // Expected reason bit from the enables and masks
  function automatic int exp_reason(input int k);
    int b;
    bit en;
    b = rb[k];
    if (b < 0) return 0;
    en = cmd_m[1];
    if (b == 7) en &= bctl_m[1];
    else if (b == 6) en &= bctl_m[2];
    else en &= !dis_m[b];
    if (b == 0) en &= cmd_m[0] & bctl_m[0];
    return int'(en) << b;
  endfunction
  task automatic run(input int k);
    seen_s = 0;
    seen_p = 0;
    seen_d = 0;
    fire(k, (k inside {[5:7]}) ? LIM : 1);
    repeat (4) @(posedge core_clk);
    e = exp_reason(k);
    check("serr", seen_s, e != 0);
    check("disc", seen_d,
      (k inside {[5:7]}) ? 1 << (k - 5) : 0);
    check("sperr", seen_p,
      k > 9 && bctl_m[0] && (k != 11 || cmd_m[0]));
    rd(BSERR_ADDR_REASON);
    check("reason", rd_v, e);
    rd(BSERR_ADDR_PSTAT);
    check("pstat", rd_v, e != 0);
    rd(BSERR_ADDR_SSTAT);
    check("sstat", rd_v, k == 0);
    wr(BSERR_ADDR_REASON, 32'hff);
    wr(BSERR_ADDR_PSTAT, 32'h1);
    wr(BSERR_ADDR_SSTAT, 32'h1);
    fire(13, 1);
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    {reg_wr, reg_rd, go, kind, reg_addr, reg_wdata} = '0;
    failures = 0;
    checks = 0;
    void'($urandom(48));
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      rd(4'(i));
      check("reset", rd_v, rst_tab[i]);
    end
    rd(4'h8);
    check("unmapped", rd_v, 32'h0);
    wr(BSERR_ADDR_LIMIT, LIM);
    wr(BSERR_ADDR_DISABLE, 32'hff);
    rd(BSERR_ADDR_DISABLE);
    check("disable", rd_v, 32'h3f);
    for (int c = 0; c < 5; c++)
    begin
      cmd_m = (c < 4) ? c_cmd[c] : $urandom_range(3);
      bctl_m = (c < 4) ? c_bctl[c] : $urandom_range(7);
      dis_m = (c < 4) ? c_dis[c] : $urandom_range(63);
      wr(BSERR_ADDR_CMD, cmd_m);
      wr(BSERR_ADDR_BCTL, bctl_m);
      wr(BSERR_ADDR_DISABLE, dis_m);
      rd(BSERR_ADDR_BCTL);
      check("bctl", rd_v, bctl_m);
      for (int k = 0; k < 13; k++) run(k);
    end
    end_of_test();
  end
  initial
  begin
    #200000;
    failures++;
    end_of_test();
  end
endmodule // bserr_top_tb
